// file: verilog/otp_security_control.sv
// per-tile otp controller: loads the protection word, copies otp to sram,
// gates debug, link and programming paths. avalon-mm slave for software.
// assumes sram write port accepts one word per cycle while boot is held.
//
// Notes on behaviour
// - protection bit 0 refuses all debug access to tile state and memory.
// - bit 1 blocks other tiles reaching processor state via the switch.
// - bit 5 starts execution at otp address 0, bypassing boot rom.
// - bit 7 enables redundant otp rows.
// - bits 8..11 each lock CMD_PROG programming of otp sectors 0..3; CMD_PSEC ignores them.
// - bit 12 rejects every programming attempt, including the protection word.
// - bit 13 blocks debug-port otp reads and writes.
// - bits 15..21 are a software field with no hardware effect.
// - bits 22..31 hold the user identifier extension.
// - protection word loads from otp before protections apply.
// - array is 8 kb: four sectors of 512 rows of 32 bits.
// - remaining otp is copied to sram, and executed first when bit 5 is set.
// - secure-boot clear means boot from internal flash.
// - debug user code takes its id field from bits 22..31.
`timescale 1ns/1ps
module otp_security_control
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   // avalon-mm slave
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output      logic [31:0] o_avs_readdata,
   output      logic        o_avs_waitrequest,
   // debug and switch requests
   input  wire logic        i_dbg_req,
   input  wire logic        i_link_req,
   // sram copy port
   output      logic        o_sram_we,
   output      logic [10:0] o_sram_addr,
   output      logic [31:0] o_sram_wdata,
   // tile control
   output      logic        o_boot_done,
   output      logic        o_boot_from_otp,
   output      logic        o_boot_from_flash,
   output      logic [31:0] o_boot_addr,
   output      logic        o_dbg_grant,
   output      logic        o_link_grant,
   output      logic        o_redundant_en,
   output      logic [9:0]  o_user_identifier_extension
);
   import otp_security_pkg::*;

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   ctrl_state_t state_ff;
   logic [31:0] prot_ff;
   logic [15:0] addr_port_ff;
   logic [31:0] data_port_ff;
   logic [15:0] ctrl_port_ff;
   logic [31:0] rdata_ff;
   logic        loaded_ff;
   logic        rejected_ff;
   logic        done_ff;
   logic [10:0] row_ff;
   logic        rd_pend_ff;
   logic [15:0] prog_cnt_ff;
   logic        ack_ff;
   logic [31:0] avs_rdata_ff;
   logic [31:0] arr_rdata;
   logic [10:0] arr_addr;
   logic        arr_rd;
   logic        arr_prog;
   logic [31:0] arr_wdata;

   logic        wr_hit;
   logic        rd_hit;
   logic        cmd_go;
   logic [1:0]  cmd;
   logic        prog_ok;
   logic [1:0]  tgt_sector;
   logic        from_dbg;

   // one wait cycle: waitrequest drops on the cycle after the request;
   // a write lands only at the edge that sees waitrequest low
   assign wr_hit = i_avs_write && ack_ff;
   assign rd_hit = i_avs_read && !ack_ff;
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_ff;
   assign o_avs_readdata = avs_rdata_ff;

   assign cmd = i_avs_writedata[1:0];
   assign from_dbg = i_avs_writedata[CTRL_DBG_SRC];
   assign cmd_go = wr_hit && (i_avs_address == REG_PROG_CTRL) && i_avs_byteenable[0]
                   && (state_ff == ST_IDLE) && (cmd != CMD_NONE);
   assign tgt_sector = addr_port_ff[10:9];

   // -------------------------------------------------------------
   // programming permission
   // -------------------------------------------------------------
   always_comb
   begin
      prog_ok = 1'b1;
      if (prot_ff[BIT_MASTER_LOCK])
      begin
         prog_ok = 1'b0;
      end
      else if (cmd == CMD_PROG && prot_ff[BIT_SECTOR_LOCK + 32'(tgt_sector)])
      begin
         prog_ok = 1'b0;
      end
      if (from_dbg && prot_ff[BIT_DBG_OTP_OFF])
      begin
         prog_ok = 1'b0;
      end
      if (from_dbg && prot_ff[BIT_DBG_OFF])
      begin
         prog_ok = 1'b0;
      end
   end

   // -------------------------------------------------------------
   // array port mux
   // -------------------------------------------------------------
   always_comb
   begin
      arr_addr  = row_ff;
      arr_rd    = 1'b0;
      arr_prog  = 1'b0;
      arr_wdata = data_port_ff;
      case (state_ff)
         ST_LOAD_SEC:
         begin
            arr_addr = OTP_SEC_WORD_ROW;
            arr_rd   = !rd_pend_ff;
         end
         ST_COPY:
         begin
            arr_rd = 1'b1;
         end
         ST_PROG:
         begin
            arr_addr = ctrl_port_ff[1:0] == CMD_PSEC ? OTP_SEC_WORD_ROW
                                                     : addr_port_ff[10:0];
            arr_prog = (prog_cnt_ff == 16'h0001);
         end
         ST_READ:
         begin
            arr_addr = addr_port_ff[10:0];
            arr_rd   = !rd_pend_ff;
         end
         default:
         begin
            arr_rd = 1'b0;
         end
      endcase
   end

   otp_array u_otp_array
   (
      .i_clk      (i_clk),
      .i_rst_b    (i_rst_b),
      .i_addr     (arr_addr),
      .i_rd       (arr_rd),
      .i_prog     (arr_prog),
      .i_wdata    (arr_wdata),
      .o_rdata_ff (arr_rdata)
   );

   // -------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         state_ff    <= ST_LOAD_SEC;
         prot_ff     <= 32'h0000_0000;
         loaded_ff   <= 1'b0;
         done_ff     <= 1'b0;
         row_ff      <= 11'h000;
         rd_pend_ff  <= 1'b0;
         prog_cnt_ff <= 16'h0000;
         rdata_ff    <= 32'h0000_0000;
         rejected_ff <= 1'b0;
         ctrl_port_ff <= 16'h0000;
      end
      else
      begin
         case (state_ff)
            ST_LOAD_SEC:
            begin
               rd_pend_ff <= 1'b1;
               if (rd_pend_ff)
               begin
                  prot_ff    <= arr_rdata;
                  loaded_ff  <= 1'b1;
                  rd_pend_ff <= 1'b0;
                  state_ff   <= ST_COPY;
               end
            end
            ST_COPY:
            begin
               row_ff <= row_ff + 11'h001;
               if (row_ff == OTP_SEC_WORD_ROW)
               begin
                  done_ff  <= 1'b1;
                  state_ff <= ST_IDLE;
               end
            end
            ST_IDLE:
            begin
               if (cmd_go)
               begin
                  ctrl_port_ff <= i_avs_writedata[15:0];
                  if (cmd == CMD_READ && !(from_dbg && (prot_ff[BIT_DBG_OTP_OFF]
                                          || prot_ff[BIT_DBG_OFF])))
                  begin
                     state_ff    <= ST_READ;
                     rejected_ff <= 1'b0;
                  end
                  else if (cmd != CMD_READ && prog_ok)
                  begin
                     state_ff    <= ST_PROG;
                     prog_cnt_ff <= 16'(PROG_CYCLES);
                     rejected_ff <= 1'b0;
                  end
                  else
                  begin
                     rejected_ff <= 1'b1;
                  end
               end
            end
            ST_PROG:
            begin
               prog_cnt_ff <= prog_cnt_ff - 16'h0001;
               if (prog_cnt_ff == 16'h0001)
               begin
                  state_ff <= ST_IDLE;
               end
            end
            ST_READ:
            begin
               rd_pend_ff <= 1'b1;
               if (rd_pend_ff)
               begin
                  rdata_ff   <= arr_rdata;
                  rd_pend_ff <= 1'b0;
                  state_ff   <= ST_IDLE;
               end
            end
            default:
            begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // bus registers
   // -------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         addr_port_ff <= 16'h0000;
         data_port_ff <= 32'h0000_0000;
         ack_ff       <= 1'b0;
         avs_rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         ack_ff <= (i_avs_read || i_avs_write) && !ack_ff;
         if (wr_hit && i_avs_address == REG_PROG_ADDR)
         begin
            addr_port_ff <= i_avs_writedata[15:0];
         end
         if (wr_hit && i_avs_address == REG_PROG_DATA)
         begin
            data_port_ff <= i_avs_writedata;
         end
         if (rd_hit)
         begin
            case (i_avs_address)
               REG_PROT_WORD: avs_rdata_ff <= prot_ff;
               REG_PROG_ADDR: avs_rdata_ff <= {16'h0000, addr_port_ff};
               REG_PROG_DATA: avs_rdata_ff <= data_port_ff;
               REG_PROG_CTRL: avs_rdata_ff <= {16'h0000, ctrl_port_ff};
               REG_STATUS:    avs_rdata_ff <= {27'h0, rejected_ff, done_ff, loaded_ff,
                                               state_ff == ST_PROG || state_ff == ST_READ,
                                               state_ff == ST_IDLE};
               REG_READ_DATA: avs_rdata_ff <= rdata_ff;
               default:       avs_rdata_ff <= UNMAPPED_DATA;
            endcase
         end
      end
   end

   // -------------------------------------------------------------
   // gated outputs: nothing granted until the word has loaded
   // -------------------------------------------------------------
   assign o_sram_we    = (state_ff == ST_COPY) && (row_ff != 11'h000);
   assign o_sram_addr  = row_ff - 11'h001;
   assign o_sram_wdata = arr_rdata;
   assign o_boot_done  = done_ff;
   assign o_boot_from_otp   = done_ff && prot_ff[BIT_SECURE_BOOT];
   assign o_boot_from_flash = done_ff && !prot_ff[BIT_SECURE_BOOT];
   assign o_boot_addr  = 32'h0000_0000;
   assign o_dbg_grant  = loaded_ff && i_dbg_req && !prot_ff[BIT_DBG_OFF];
   assign o_link_grant = loaded_ff && i_link_req && !prot_ff[BIT_LINK_OFF];
   assign o_redundant_en = loaded_ff && prot_ff[BIT_REDUNDANT];
   assign o_user_identifier_extension = prot_ff[UID_HI:UID_LO];
endmodule : otp_security_control

// file: verilog/otp_security_pkg.sv
// package for the otp security controller: register map, field positions, geometry.
// assumes a single 25 mhz clock domain and avalon-mm word addressing by byte.
package otp_security_pkg;
   // -------------------------------------------------------------
   // geometry
   // -------------------------------------------------------------
   localparam int OTP_SECTORS      = 4;
   localparam int OTP_ROWS_PER_SEC = 512;
   localparam int OTP_WORD_W       = 32;
   localparam int OTP_ADDR_W       = 11;
   localparam int OTP_DEPTH        = OTP_SECTORS * OTP_ROWS_PER_SEC;
   localparam int OTP_REDUNDANT    = 4;
   localparam logic [10:0] OTP_SEC_WORD_ROW = 11'h7ff;

   // -------------------------------------------------------------
   // protection word fields
   // -------------------------------------------------------------
   localparam int BIT_DBG_OFF      = 0;
   localparam int BIT_LINK_OFF     = 1;
   localparam int BIT_SECURE_BOOT  = 5;
   localparam int BIT_REDUNDANT    = 7;
   localparam int BIT_SECTOR_LOCK  = 8;
   localparam int BIT_MASTER_LOCK  = 12;
   localparam int BIT_DBG_OTP_OFF  = 13;
   localparam int GP_LO            = 15;
   localparam int GP_HI            = 21;
   localparam int UID_LO           = 22;
   localparam int UID_HI           = 31;

   // -------------------------------------------------------------
   // register map (byte addresses)
   // -------------------------------------------------------------
   localparam logic [7:0] REG_PROT_WORD  = 8'h00;
   localparam logic [7:0] REG_PROG_ADDR  = 8'h04;
   localparam logic [7:0] REG_PROG_DATA  = 8'h08;
   localparam logic [7:0] REG_PROG_CTRL  = 8'h0c;
   localparam logic [7:0] REG_STATUS     = 8'h10;
   localparam logic [7:0] REG_READ_DATA  = 8'h14;

   // control command codes, written to REG_PROG_CTRL[1:0]
   localparam logic [1:0] CMD_NONE  = 2'h0;
   localparam logic [1:0] CMD_PROG  = 2'h1;
   localparam logic [1:0] CMD_READ  = 2'h2;
   localparam logic [1:0] CMD_PSEC  = 2'h3;
   localparam int CTRL_DBG_SRC       = 4;

   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_HZ       = 25_000_000;
   localparam int PROG_TIME_US = 10;
   localparam int PROG_CYCLES  = (PROG_TIME_US * (CLK_HZ / 1_000_000));

   typedef enum logic [2:0]
   {
      ST_LOAD_SEC  = 3'b000,
      ST_COPY      = 3'b001,
      ST_IDLE      = 3'b010,
      ST_PROG      = 3'b011,
      ST_READ      = 3'b100
   } ctrl_state_t;
endpackage : otp_security_pkg

// file: verilog/otp_array.sv
// otp bit array with one-way programming (bits may only go from zero to one).
// assumes the controller serialises reads and programs.
`timescale 1ns/1ps
module otp_array
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic [10:0] i_addr,
   input  wire logic        i_rd,
   input  wire logic        i_prog,
   input  wire logic [31:0] i_wdata,
   output      logic [31:0] o_rdata_ff
);
   import otp_security_pkg::*;

   // contents survive reset; only power loss would clear a real array
   // unprogrammed cells read as zero, as a blank part does
   logic [31:0] cells [0:OTP_DEPTH-1] = '{default: 32'h0000_0000};

   // -------------------------------------------------------------
   // programming: or-in only, so a set bit can never clear
   // -------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_prog)
      begin
         cells[i_addr] <= cells[i_addr] | i_wdata;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_rdata_ff <= 32'h0000_0000;
      end
      else if (i_rd)
      begin
         o_rdata_ff <= cells[i_addr];
      end
   end
endmodule : otp_array

// file: verification/otp_security_control_chk.sv
// checker for otp_security_control: boot, copy and bus timing relations.
// assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
module otp_security_control_chk
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic        o_avs_waitrequest,
   input  wire logic        o_sram_we,
   input  wire logic [10:0] o_sram_addr,
   input  wire logic        o_boot_done,
   input  wire logic        o_boot_from_otp,
   input  wire logic        o_boot_from_flash,
   input  wire logic [31:0] o_boot_addr,
   input  wire logic        o_redundant_en,
   input  wire logic [9:0]  o_user_identifier_extension
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   chk_boot_one_src: assert property (o_boot_done |-> o_boot_from_otp != o_boot_from_flash)
      else $error("boot source not exactly one");
   chk_boot_addr_zero: assert property (o_boot_from_otp |-> o_boot_addr == 32'h0)
      else $error("otp boot address not zero");
   chk_bus_one_wait: assert property ($rose(i_avs_read || i_avs_write)
      |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("bus answer not after one wait state");
   chk_copy_before_boot: assert property (o_sram_we |-> !o_boot_done)
      else $error("sram write after boot done");
   chk_copy_addr_step: assert property (o_sram_we ##1 o_sram_we
      |-> o_sram_addr == $past(o_sram_addr) + 11'h1)
      else $error("sram copy address not incrementing");
   chk_boot_done_hold: assert property (o_boot_done |=> o_boot_done)
      else $error("boot done dropped");
   chk_uid_stable: assert property (o_boot_done |=> $stable(o_user_identifier_extension))
      else $error("user id changed after boot");
   chk_prot_stable: assert property (o_boot_done
      |=> $stable(o_redundant_en) && $stable(o_boot_from_otp))
      else $error("protection outputs changed after boot");
endmodule : otp_security_control_chk

bind otp_security_control otp_security_control_chk chk_i (.i_clk, .i_rst_b, .i_avs_read,
   .i_avs_write, .o_avs_waitrequest, .o_sram_we, .o_sram_addr, .o_boot_done, .o_boot_from_otp,
   .o_boot_from_flash, .o_boot_addr, .o_redundant_en, .o_user_identifier_extension);

// file: verification/otp_security_control_tb.sv
// testbench for otp_security_control: boot, programming and lock scenarios.
// assumes the otp array powers up all zero, as an unprogrammed part does.
`timescale 1ns/1ps
module otp_security_control_tb;
   import otp_security_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_rst_b = 1'b0;
   logic [7:0]  i_avs_address = 8'h00;
   logic        i_avs_read = 1'b0;
   logic        i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic        i_dbg_req = 1'b0;
   logic        i_link_req = 1'b0;
   logic [31:0] o_avs_readdata, o_boot_addr, o_sram_wdata, q, st;
   logic        o_avs_waitrequest, o_sram_we, o_boot_done, o_boot_from_otp;
   logic        o_boot_from_flash, o_dbg_grant, o_link_grant, o_redundant_en;
   logic [10:0] o_sram_addr;
   logic [9:0]  o_user_identifier_extension;
   int          n_mismatch = 0;
   int          compares = 0;
   int          cycles = 0;
   int          copy_cnt = 0;
   logic [31:0] copy_w200 = 32'h0;
   localparam logic [31:0] W = {10'h2b5, 7'h7f, 15'h21a3};

   otp_security_control uut (.i_clk, .i_rst_b, .i_avs_address, .i_avs_read, .i_avs_write,
      .i_avs_writedata, .i_avs_byteenable(4'hf), .o_avs_readdata, .o_avs_waitrequest,
      .i_dbg_req, .i_link_req, .o_sram_we, .o_sram_addr, .o_sram_wdata, .o_boot_done,
      .o_boot_from_otp, .o_boot_from_flash, .o_boot_addr, .o_dbg_grant, .o_link_grant,
      .o_redundant_en, .o_user_identifier_extension);

   always #20 i_clk = ~i_clk;
   // a hang anywhere ends the run through the same report
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end

   // copy monitor: counts sram writes and keeps one known row
   always @(posedge i_clk)
   begin
      if (o_sram_we === 1'b1)
      begin
         copy_cnt++;
         if (o_sram_addr === 11'h200)
            copy_w200 = o_sram_wdata;
      end
   end

   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_read <= !wr;
      i_avs_write <= wr;
      do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
      q = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask : bus

   // status is polled, not counted: programming time is the design's own
   task automatic op(input logic [10:0] row, input logic [31:0] d, input logic [7:0] c);
      bus(1'b1, REG_PROG_ADDR, {21'h0, row});
      bus(1'b1, REG_PROG_DATA, d);
      bus(1'b1, REG_PROG_CTRL, {24'h0, c});
      do bus(1'b0, REG_STATUS, 32'h0); while (q[1] !== 1'b0 || q[0] !== 1'b1);
      st = q;
   endtask : op

   task automatic rdrow(input logic [10:0] row, input logic [7:0] c);
      op(row, 32'h0, c);
      bus(1'b0, REG_READ_DATA, 32'h0);
   endtask : rdrow

   task automatic reboot();
      @(posedge i_clk);
      i_rst_b <= 1'b0;
      repeat (16) @(posedge i_clk);
      copy_cnt = 0;
      i_rst_b <= 1'b1;
      do @(posedge i_clk); while (o_boot_done !== 1'b1);
   endtask : reboot

   task automatic t_blank();
      reboot();
      bus(1'b0, REG_PROT_WORD, 32'h0);
      check("prot", q, 32'h0);
      check("copy_cnt", 32'(copy_cnt), 32'(OTP_DEPTH - 1));
      check("dbg_off", {31'h0, o_dbg_grant}, 32'h0);
      i_dbg_req <= 1'b1;
      i_link_req <= 1'b1;
      @(posedge i_clk);
      @(negedge i_clk);
      check("dbg", {31'h0, o_dbg_grant}, 32'h1);
      check("link", {31'h0, o_link_grant}, 32'h1);
      check("flash", {30'h0, o_boot_from_flash, o_boot_from_otp}, 32'h2);
      check("redund", {31'h0, o_redundant_en}, 32'h0);
      check("uid", {22'h0, o_user_identifier_extension}, 32'h0);
      bus(1'b0, 8'h40, 32'h0);
      check("unmapped", q, UNMAPPED_DATA);
      bus(1'b1, REG_PROT_WORD, 32'hffff_ffff);
      bus(1'b0, REG_PROT_WORD, 32'h0);
      check("prot_ro", q, 32'h0);
      $display("blank boot done");
   endtask : t_blank

   task automatic t_rows();
      op(11'h200, 32'ha5a5_0f0f, {6'h0, CMD_PROG});
      op(11'h200, 32'h0000_f0f0, {6'h0, CMD_PROG});
      rdrow(11'h200, {6'h0, CMD_READ});
      check("row_or", q, 32'ha5a5_ffff);
      op(11'h7fe, 32'h8000_0001, {6'h0, CMD_PROG});
      rdrow(11'h7fe, {6'h0, CMD_READ});
      check("row_top", q, 32'h8000_0001);
      $display("row programming done");
   endtask : t_rows

   task automatic t_secure();
      op(11'h0, W, {6'h0, CMD_PSEC});
      reboot();
      bus(1'b0, REG_PROT_WORD, 32'h0);
      check("prot", q, W);
      check("gp_field", {25'h0, q[21:15]}, 32'h7f);
      check("copy_cnt", 32'(copy_cnt), 32'(OTP_DEPTH - 1));
      check("copy_row", copy_w200, 32'ha5a5_ffff);
      @(negedge i_clk);
      check("grants", {30'h0, o_dbg_grant, o_link_grant}, 32'h0);
      check("otp_boot", {30'h0, o_boot_from_flash, o_boot_from_otp}, 32'h1);
      check("redund", {31'h0, o_redundant_en}, 32'h1);
      check("uid", {22'h0, o_user_identifier_extension}, 32'h2b5);
      op(11'h010, 32'h1, {6'h0, CMD_PROG});
      check("sec0_rej", {31'h0, st[4]}, 32'h1);
      rdrow(11'h010, {6'h0, CMD_READ});
      check("sec0_row", q, 32'h0);
      op(11'h201, 32'h1, {6'h0, CMD_PROG});
      rdrow(11'h201, {6'h0, CMD_READ});
      check("sec1_row", q, 32'h1);
      rdrow(11'h201, 8'h12);
      check("dbg_rej", {31'h0, st[4]}, 32'h1);
      $display("secure word done");
   endtask : t_secure

   task automatic t_master();
      op(11'h0, 32'h0000_1000, {6'h0, CMD_PSEC});
      op(11'h0, 32'h0, {6'h0, CMD_PSEC});
      reboot();
      bus(1'b0, REG_PROT_WORD, 32'h0);
      check("prot_or", q, W | 32'h0000_1000);
      op(11'h400, 32'h3, {6'h0, CMD_PROG});
      check("prog_rej", {31'h0, st[4]}, 32'h1);
      rdrow(11'h400, {6'h0, CMD_READ});
      check("sec2_row", q, 32'h0);
      op(11'h0, 32'h4, {6'h0, CMD_PSEC});
      check("psec_rej", {31'h0, st[4]}, 32'h1);
      $display("master lock done");
   endtask : t_master

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   initial
   begin
      t_blank();
      t_rows();
      t_secure();
      t_master();
      report_and_stop();
   end
endmodule : otp_security_control_tb
